// [design/fwrc_ctrl.sv]
`timescale 1ns/10ps
module fwrc_ctrl #(
  parameter int unsigned RCH_CYC  = fwrc_pkg::CYC_RCH,
  parameter int unsigned DP_CYC   = fwrc_pkg::CYC_DP,
  parameter int unsigned RES1_CYC = fwrc_pkg::CYC_RES1,
  parameter int unsigned RES2_CYC = fwrc_pkg::CYC_RES2,
  parameter int unsigned RST_CYC  = fwrc_pkg::CYC_RST,
  parameter logic [7:0]  DEVICE_ID = 8'h5A  // Arbitrary value
) (
  input  wire logic        REF_CLK,
  input  wire logic        NRST,
  input  wire logic        CE,
  input  wire logic        CS_N,
  input  wire logic        SCLK,
  input  wire logic [3:0]  IO_IN,
  input  wire logic        QUAD_MODE,
  input  wire logic        QUAD_ENABLE,
  input  wire logic        BUSY,
  input  wire logic [7:0]  ARRAY_DATA,
  output logic      [3:0]  IO_OUT,
  output logic      [3:0]  IO_OE_N,
  output logic      [2:0]  WRAP_SETTING,
  output logic      [7:0]  READ_PARAM,
  output logic             POWER_DOWN,
  output logic             SW_RESET,
  output logic             CONT_READ,
  output logic      [23:0] RD_ADDR,
  output logic             RD_NEXT,
  output logic             READY
);
  import fwrc_pkg::*;

  localparam int TW        = 16;
  localparam int A_DP_MAX  = DP_CYC + 3;
  localparam int A_WK_MAX  = ((RES1_CYC > RES2_CYC) ? RES1_CYC : RES2_CYC) + 3;

  function automatic logic [3:0] dummy_clocks(input logic [1:0] sel);
    case (sel)
      2'h0:    dummy_clocks = 4'h4;
      2'h1:    dummy_clocks = 4'h6;
      default: dummy_clocks = 4'h8;
    endcase
  endfunction

  function automatic logic [5:0] lanes(input logic wide);
    lanes = wide ? 6'h04 : 6'h01;
  endfunction

  function automatic logic [23:0] next_addr(input logic [23:0] a, input logic on,
                                            input logic [1:0] len);
    logic [23:0] inc;
    logic [23:0] mask;
    inc  = a + 24'h00_0001;
    mask = {18'h0, 6'((7'h08 << len) - 7'h01)};
    next_addr = on ? ((a & ~mask) | (inc & mask)) : inc;
  endfunction

  logic [5:0]  pin_s;
  logic        cs_n_s;
  logic        sclk_s;
  logic [3:0]  io_s;

  // Pins cross from the host clock; only the second stage is read
  fwrc_sync #(.W(6), .INIT(6'h20)) u_sync (
    .clk  (REF_CLK),
    .nrst (NRST),
    .ce   (CE),
    .d    ({CS_N, SCLK, IO_IN}),
    .q    (pin_s)
  );
  assign {cs_n_s, sclk_s, io_s} = pin_s;

  fwrc_tmr_if #(.W(TW)) tmr_if ();

  fwrc_timer #(.W(TW)) u_timer (
    .clk  (REF_CLK),
    .nrst (NRST),
    .ce   (CE),
    .t    (tmr_if.tmr)
  );

  fwrc_state_t state_ff;
  fwrc_act_t   act_ff;
  fwrc_tkind_t tkind_ff;
  logic        sclk_d_ff;
  logic        cs_d_ff;
  logic [7:0]  op_ff;
  logic [7:0]  cont_op_ff;
  logic [31:0] sh_ff;
  logic [5:0]  cnt_ff;
  logic [3:0]  dum_ff;
  logic        wide_ff;
  logic        ddr_ff;
  logic        qpi_ff;
  logic        rst_en_ff;
  logic        wrap_on_ff;
  logic [1:0]  wlen_ff;
  logic [7:0]  out_sh_ff;
  logic [3:0]  left_ff;
  logic [TW-1:0] hold_ff;

  logic rise, fall, cs_fall, cs_rise, samp, out_edge, is_id;
  logic [31:0] in_bits;
  logic [7:0]  in_byte;
  logic [5:0]  cnt_n;
  logic [7:0]  cur_byte;
  logic opc_done, addr_done, mode_done, wrap_ld, prm_ld;
  logic sw_exec, dp_go, wake_go, hold_ok;
  logic [3:0]  mode_extra;

  assign rise     = ~cs_n_s & sclk_s & ~sclk_d_ff;
  assign fall     = ~cs_n_s & ~sclk_s & sclk_d_ff;
  assign cs_fall  = cs_d_ff & ~cs_n_s;
  assign cs_rise  = ~cs_d_ff & cs_n_s;
  // Double rate samples both edges only for address and mode bits
  assign samp     = rise | (fall & ddr_ff & ((state_ff == ST_ADDR) | (state_ff == ST_MODE)));
  assign in_bits  = wide_ff ? {sh_ff[27:0], io_s} : {sh_ff[30:0], io_s[0]};
  assign in_byte  = in_bits[7:0];
  assign cnt_n    = cnt_ff + lanes(wide_ff);
  assign is_id    = (op_ff == OP_WAKE);
  assign out_edge = (state_ff == ST_DATA) & (fall | (ddr_ff & rise));
  assign cur_byte = (left_ff == 4'h0) ? (is_id ? DEVICE_ID : ARRAY_DATA) : out_sh_ff;

  assign opc_done  = (state_ff == ST_CMD) & samp & (cnt_n == OPC_BITS);
  assign addr_done = (state_ff == ST_ADDR) & samp & (cnt_n == ADDR_BITS);
  assign mode_done = (state_ff == ST_MODE) & samp & (cnt_n == MODE_BITS);
  assign wrap_ld   = (state_ff == ST_ARG) & samp & (op_ff == OP_SETWRAP)
                   & (cnt_n == WRAPCMD_BITS);
  assign prm_ld    = (state_ff == ST_ARG) & samp & (op_ff == OP_RDPARAM)
                   & (cnt_n == PARAM_BITS);
  assign mode_extra = qpi_ff ? (dummy_clocks(READ_PARAM[DUMSEL_LSB+:2]) - DUMMY_DEFAULT)
                             : SPI_QIO_DUMMY;

  assign hold_ok = (hold_ff >= TW'(RCH_CYC));
  assign sw_exec = cs_rise & (state_ff == ST_HOLD) & (act_ff == ACT_RST) & rst_en_ff
                 & hold_ok & ~POWER_DOWN & ~CONT_READ;
  assign dp_go   = cs_rise & (state_ff == ST_HOLD) & (act_ff == ACT_SLEEP);
  assign wake_go = cs_rise & (act_ff == ACT_WAKE) & POWER_DOWN
                 & ((state_ff == ST_ARG) | (state_ff == ST_DATA));

  assign tmr_if.load  = dp_go | wake_go | sw_exec;
  always_comb begin
    if (dp_go)
      tmr_if.count = TW'(DP_CYC);
    else if (sw_exec)
      tmr_if.count = TW'(RST_CYC);
    else if ((state_ff == ST_ARG) && (cnt_ff == 6'h00))
      tmr_if.count = TW'(RES1_CYC);
    else
      tmr_if.count = TW'(RES2_CYC);
  end

  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      sclk_d_ff <= 1'b0;
      cs_d_ff   <= 1'b1;
      hold_ff   <= '0;
    end else if (CE) begin
      sclk_d_ff <= sclk_s;
      cs_d_ff   <= cs_n_s;
      if (rise)
        hold_ff <= '0;
      else if (!hold_ok)
        hold_ff <= hold_ff + 1'b1;
    end
  end

  // Frame sequencer
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      state_ff <= ST_IDLE;
      act_ff   <= ACT_NONE;
      op_ff    <= 8'h00;
      sh_ff    <= 32'h0000_0000;
      cnt_ff   <= 6'h00;
      dum_ff   <= 4'h0;
      wide_ff  <= 1'b0;
      ddr_ff   <= 1'b0;
      qpi_ff   <= 1'b0;
    end else if (CE) begin
      if (cs_n_s) begin
        state_ff <= ST_IDLE;
        cnt_ff   <= 6'h00;
      end else if (cs_fall) begin
        cnt_ff <= 6'h00;
        act_ff <= ACT_NONE;
        qpi_ff <= QUAD_MODE;
        if (CONT_READ) begin
          state_ff <= ST_ADDR;
          op_ff    <= cont_op_ff;
          wide_ff  <= 1'b1;
          ddr_ff   <= (cont_op_ff == OP_DQIO);
        end else begin
          state_ff <= ST_CMD;
          wide_ff  <= QUAD_MODE;
          ddr_ff   <= 1'b0;
        end
      end else if (samp) begin
        sh_ff  <= in_bits;
        cnt_ff <= cnt_n;
        case (state_ff)
          ST_CMD: if (cnt_n == OPC_BITS) begin
            cnt_ff <= 6'h00;
            op_ff  <= in_byte;
            // Recovery windows swallow every command
            if (tmr_if.busy) begin
              state_ff <= ST_IGN;
            end else if (POWER_DOWN && in_byte != OP_WAKE) begin
              state_ff <= ST_IGN;
            end else begin
              case (in_byte)
                OP_WAKE: begin
                  state_ff <= BUSY ? ST_IGN : ST_ARG;
                  act_ff   <= BUSY ? ACT_NONE : ACT_WAKE;
                end
                OP_QIO, OP_DQIO: begin
                  state_ff <= QUAD_ENABLE ? ST_ADDR : ST_IGN;
                  wide_ff  <= 1'b1;
                  ddr_ff   <= (in_byte == OP_DQIO);
                end
                OP_WRAPRD: begin
                  state_ff <= qpi_ff ? ST_ADDR : ST_IGN;
                  ddr_ff   <= 1'b1;
                end
                OP_SETWRAP: begin
                  // Dummy and wrap bits always arrive on four lines
                  state_ff <= QUAD_ENABLE ? ST_ARG : ST_IGN;
                  wide_ff  <= 1'b1;
                end
                OP_RDPARAM: state_ff <= ST_ARG;
                OP_SLEEP: begin
                  state_ff <= ST_HOLD;
                  act_ff   <= ACT_SLEEP;
                end
                OP_RSTEN: begin
                  state_ff <= ST_HOLD;
                  act_ff   <= ACT_RSTEN;
                end
                OP_RST: begin
                  state_ff <= ST_HOLD;
                  act_ff   <= ACT_RST;
                end
                default: state_ff <= ST_IGN;
              endcase
            end
          end
          ST_ADDR: if (cnt_n == ADDR_BITS) begin
            cnt_ff <= 6'h00;
            if (op_ff == OP_WRAPRD) begin
              state_ff <= ST_DUMMY;
              dum_ff   <= dummy_clocks(READ_PARAM[DUMSEL_LSB+:2]);
            end else begin
              state_ff <= ST_MODE;
            end
          end
          ST_MODE: if (cnt_n == MODE_BITS) begin
            cnt_ff   <= 6'h00;
            dum_ff   <= mode_extra;
            state_ff <= (mode_extra == 4'h0) ? ST_DATA : ST_DUMMY;
          end
          ST_DUMMY: if (dum_ff <= 4'h1) begin
            state_ff <= ST_DATA;
          end else begin
            dum_ff <= dum_ff - 4'h1;
          end
          ST_ARG: if ((op_ff == OP_WAKE) && (cnt_n == IDDUMMY_BITS)) begin
            state_ff <= ST_DATA;
          end else if (wrap_ld || prm_ld) begin
            state_ff <= ST_HOLD;
          end
          ST_HOLD: begin
            // A clock past the last byte voids pending actions
            state_ff <= ST_IGN;
            act_ff   <= ACT_NONE;
          end
          default: ;
        endcase
      end
    end
  end

  // Read data path and wrap address
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      IO_OUT     <= 4'h0;
      IO_OE_N    <= 4'hF;
      out_sh_ff  <= 8'h00;
      left_ff    <= 4'h0;
      RD_ADDR    <= 24'h00_0000;
      RD_NEXT    <= 1'b0;
      wrap_on_ff <= 1'b0;
      wlen_ff    <= 2'h0;
    end else if (CE) begin
      RD_NEXT <= 1'b0;
      if (addr_done) begin
        RD_ADDR    <= in_bits[23:0];
        wlen_ff    <= WRAP_SETTING[2:1];
        // Fixed wrap opcode always wraps; quad mode never wraps others
        wrap_on_ff <= (op_ff == OP_WRAPRD) | (~qpi_ff & ~WRAP_SETTING[0]);
      end
      if (state_ff != ST_DATA) begin
        IO_OE_N <= 4'hF;
        left_ff <= 4'h0;
      end else if (out_edge) begin
        if (wide_ff) begin
          IO_OUT    <= cur_byte[7:4];
          IO_OE_N   <= 4'h0;
          out_sh_ff <= {cur_byte[3:0], 4'h0};
          left_ff   <= (left_ff == 4'h0) ? 4'h4 : left_ff - 4'h4;
        end else begin
          IO_OUT    <= {2'h0, cur_byte[7], 1'b0};
          IO_OE_N   <= 4'hD;
          out_sh_ff <= {cur_byte[6:0], 1'b0};
          left_ff   <= (left_ff == 4'h0) ? 4'h7 : left_ff - 4'h1;
        end
        if ((left_ff == 4'h0) && !is_id) begin
          RD_ADDR <= next_addr(RD_ADDR, wrap_on_ff, wlen_ff);
          RD_NEXT <= 1'b1;
        end
      end
    end
  end

  // Volatile settings and reset sequence
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      WRAP_SETTING <= WRAP_RST;
      READ_PARAM   <= RDPARAM_RST;
      SW_RESET     <= 1'b0;
      rst_en_ff    <= 1'b0;
    end else if (CE) begin
      SW_RESET <= sw_exec;
      if (sw_exec) begin
        WRAP_SETTING <= WRAP_RST;
        READ_PARAM   <= RDPARAM_RST;
        rst_en_ff    <= 1'b0;
      end else begin
        if (wrap_ld)
          WRAP_SETTING <= in_byte[WRAP_FIELD_LSB+:3];
        if (prm_ld) begin
          READ_PARAM        <= in_byte;
          WRAP_SETTING[2:1] <= in_byte[1:0];
        end
        if (opc_done && in_byte != OP_RST)
          rst_en_ff <= 1'b0;
        else if (cs_rise && state_ff == ST_HOLD && act_ff == ACT_RSTEN)
          rst_en_ff <= 1'b1;
      end
    end
  end

  // Continuous read survives software reset by design
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      CONT_READ  <= 1'b0;
      cont_op_ff <= OP_QIO;
    end else if (CE && mode_done) begin
      CONT_READ  <= (in_byte[CONT_SEL_LSB+:2] == CONT_SEL);
      cont_op_ff <= op_ff;
    end
  end

  // Power-down entry and release
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      POWER_DOWN <= 1'b0;
      tkind_ff   <= TK_RST;
      READY      <= 1'b0;
    end else if (CE) begin
      READY <= ~tmr_if.busy & ~tmr_if.load & ~POWER_DOWN;
      if (dp_go)
        tkind_ff <= TK_SLEEP;
      else if (wake_go)
        tkind_ff <= TK_WAKE;
      else if (sw_exec)
        tkind_ff <= TK_RST;
      if (tmr_if.done && tkind_ff == TK_SLEEP)
        POWER_DOWN <= 1'b1;
      else if (tmr_if.done && tkind_ff == TK_WAKE)
        POWER_DOWN <= 1'b0;
    end
  end

  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!NRST || !CE);

  a_wrap_byte_load: assert property (
    wrap_ld |=> WRAP_SETTING == $past(in_byte[6:4])) else $error("wrap bits not loaded");
  a_qpi_no_wrap: assert property (
    addr_done && qpi_ff && op_ff != OP_WRAPRD |=> !wrap_on_ff) else $error("wrap in quad mode");
  a_wrap_follows_bit: assert property (
    addr_done && !qpi_ff && op_ff != OP_WRAPRD |=> wrap_on_ff == !$past(WRAP_SETTING[0]))
    else $error("wrap setting not applied");
  a_reset_restores: assert property (
    SW_RESET |-> WRAP_SETTING == WRAP_RST && READ_PARAM == RDPARAM_RST)
    else $error("reset left volatile state");
  a_reset_blocked: assert property (
    cs_rise && (POWER_DOWN || CONT_READ) |=> !SW_RESET) else $error("reset while blocked");
  a_rsten_cleared: assert property (
    opc_done && in_byte != OP_RST |=> !rst_en_ff) else $error("reset enable kept");
  a_sleep_only_wake: assert property (
    opc_done && POWER_DOWN && in_byte != OP_WAKE |=> state_ff == ST_IGN)
    else $error("command heard in power-down");
  a_wake_busy_ign: assert property (
    opc_done && BUSY && !tmr_if.busy && in_byte == OP_WAKE |=> state_ff == ST_IGN)
    else $error("release taken while busy");
  a_cont_skip_op: assert property (
    cs_fall && CONT_READ |=> state_ff == ST_ADDR) else $error("opcode not skipped");
  a_sleep_entry: assert property (
    dp_go |-> ##[1:A_DP_MAX] POWER_DOWN) else $error("power-down not entered");
  a_wake_exit: assert property (
    wake_go |-> ##[1:A_WK_MAX] !POWER_DOWN) else $error("power-down not released");
  a_data_after_mode: assert property (
    mode_done && qpi_ff && READ_PARAM[5:4] == 2'h0 |=> state_ff == ST_DATA)
    else $error("data not after mode bits");

  c_sw_reset: cover property (sw_exec);
  c_sleep: cover property (dp_go ##[1:A_DP_MAX] POWER_DOWN);
  c_wrap_read: cover property (RD_NEXT && wrap_on_ff && RD_ADDR[2:0] == 3'h0);
  c_cont_frame: cover property (cs_fall && CONT_READ);
endmodule

// [design/fwrc_pkg.sv]
package fwrc_pkg;

  localparam logic [7:0] OP_QIO     = 8'hEB;
  localparam logic [7:0] OP_DQIO    = 8'hED;
  localparam logic [7:0] OP_WRAPRD  = 8'h0E;
  localparam logic [7:0] OP_SETWRAP = 8'h77;
  localparam logic [7:0] OP_RDPARAM = 8'hC0;
  localparam logic [7:0] OP_RSTEN   = 8'h66;
  localparam logic [7:0] OP_RST     = 8'h99;
  localparam logic [7:0] OP_SLEEP   = 8'hB9;
  localparam logic [7:0] OP_WAKE    = 8'hAB;

  localparam logic [5:0] OPC_BITS     = 6'h08;
  localparam logic [5:0] ADDR_BITS    = 6'h18;
  localparam logic [5:0] MODE_BITS    = 6'h08;
  localparam logic [5:0] WRAPCMD_BITS = 6'h20;
  localparam logic [5:0] PARAM_BITS   = 6'h08;
  localparam logic [5:0] IDDUMMY_BITS = 6'h18;

  localparam int         WRAP_FIELD_LSB = 4;
  localparam int         CONT_SEL_LSB   = 4;
  localparam int         DUMSEL_LSB     = 4;
  localparam logic [1:0] CONT_SEL       = 2'h2;
  localparam logic [2:0] WRAP_RST       = 3'h1;
  localparam logic [7:0] RDPARAM_RST    = 8'h00;
  localparam logic [3:0] DUMMY_DEFAULT  = 4'h4;
  localparam logic [3:0] SPI_QIO_DUMMY  = 4'h4;

  localparam int CLK_NS    = 4;
  localparam int T_RCH_NS  = 20;
  localparam int T_DP_NS   = 3000;
  localparam int T_RES1_NS = 3000;
  localparam int T_RES2_NS = 1800;
  localparam int T_RST_NS  = 30000;
  localparam int CYC_RCH   = (T_RCH_NS + CLK_NS - 1) / CLK_NS;
  localparam int CYC_DP    = (T_DP_NS < CLK_NS) ? 1 : T_DP_NS / CLK_NS;
  localparam int CYC_RES1  = (T_RES1_NS < CLK_NS) ? 1 : T_RES1_NS / CLK_NS;
  localparam int CYC_RES2  = (T_RES2_NS < CLK_NS) ? 1 : T_RES2_NS / CLK_NS;
  localparam int CYC_RST   = (T_RST_NS < CLK_NS) ? 1 : T_RST_NS / CLK_NS;

  typedef enum logic [8:0] {
    ST_IDLE  = 9'h001,
    ST_CMD   = 9'h002,
    ST_ADDR  = 9'h004,
    ST_MODE  = 9'h008,
    ST_DUMMY = 9'h010,
    ST_DATA  = 9'h020,
    ST_ARG   = 9'h040,
    ST_HOLD  = 9'h080,
    ST_IGN   = 9'h100
  } fwrc_state_t;

  typedef enum logic [2:0] {
    ACT_NONE  = 3'h0,
    ACT_SLEEP = 3'h1,
    ACT_WAKE  = 3'h2,
    ACT_RSTEN = 3'h3,
    ACT_RST   = 3'h4
  } fwrc_act_t;

  typedef enum logic [1:0] {
    TK_SLEEP = 2'h0,
    TK_WAKE  = 2'h1,
    TK_RST   = 2'h2
  } fwrc_tkind_t;

endpackage

// [design/fwrc_sync.sv]
`timescale 1ns/10ps
module fwrc_sync #(
  parameter int           W    = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input  wire logic         clk,
  input  wire logic         nrst,
  input  wire logic         ce,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_ff;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      meta_ff <= INIT;
      q       <= INIT;
    end else if (ce) begin
      meta_ff <= d;
      q       <= meta_ff;
    end
  end
endmodule

// [design/fwrc_timer.sv]
`timescale 1ns/10ps
module fwrc_timer #(
  parameter int W = 16
) (
  input  wire logic clk,
  input  wire logic nrst,
  input  wire logic ce,
  fwrc_tmr_if.tmr   t
);
  logic [W-1:0] cnt_ff;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_ff <= '0;
      t.busy <= 1'b0;
      t.done <= 1'b0;
    end else if (ce) begin
      t.done <= 1'b0;
      if (t.load) begin
        cnt_ff <= t.count;
        t.busy <= 1'b1;
      end else if (cnt_ff != '0) begin
        cnt_ff <= cnt_ff - 1'b1;
        if (cnt_ff == W'(1)) begin
          t.done <= 1'b1;
          t.busy <= 1'b0;
        end
      end
    end
  end

  a_done_idle: assert property (@(posedge clk) disable iff (!nrst)
    t.done |-> !t.busy) else $error("timer done while still busy");
endmodule

// [design/fwrc_tmr_if.sv]
`timescale 1ns/10ps
interface fwrc_tmr_if #(
  parameter int W = 16
);
  logic         load;
  logic [W-1:0] count;
  logic         busy;
  logic         done;

  modport ctl (output load, output count, input busy, input done);
  modport tmr (input load, input count, output busy, output done);
endinterface

// [dv/fwrc_host.sv]
`timescale 1ns/10ps
module fwrc_host (
  input  wire logic       clk,
  input  wire logic [3:0] io_out,
  output logic            cs_n,
  output logic            sclk,
  output logic      [3:0] io_in
);
  logic [31:0] cap;
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    io_in = 4'h0;
    cap = 32'h0000_0000;
  end
  // Half of a 48 ns serial clock
  task automatic half();
    repeat (6) @(posedge clk);
  endtask
  task automatic start();
    @(posedge clk);
    cs_n <= 1'b0;
    half();
  endtask
  // MSB first; w=1 on IO0, w=4 with IO3 as MSB
  task automatic send(input logic [31:0] d, input int n, input int w);
    for (int i = n - w; i >= 0; i -= w) begin
      sclk <= 1'b0;
      io_in <= (w == 1) ? {~io_in[3:1], d[i]} : d[i+:4];
      half();
      sclk <= 1'b1;
      half();
    end
  endtask
  // Lines are released here, so they keep toggling
  task automatic clocks(input int k);
    repeat (k) begin
      sclk <= 1'b0;
      io_in <= ~io_in;
      half();
      cap <= {cap[30:0], io_out[1]};
      sclk <= 1'b1;
      half();
    end
  endtask
  // Serial clock stands low outside frames
  task automatic stop();
    sclk <= 1'b0;
    half();
    cs_n <= 1'b1;
    io_in <= ~io_in;
    half();
  endtask
endmodule

// [dv/tb_top.sv]
`timescale 1ns/10ps
module tb_top;
  import fwrc_pkg::*;
  localparam logic [7:0] ID_VAL = 8'hC3; // Arbitrary value
  logic clk = 1'b0, nrst = 1'b0, qm = 1'b0, qe = 1'b0, busy = 1'b0, ce = 1'b1;
  logic [7:0] adat = 8'h00, rparam, w, p;
  logic cs_n, sclk, sw_rst, pd, cont, rd_next, ready;
  logic [3:0] io_in, io_out, oe_n;
  logic [2:0] wrap, mws;
  logic [23:0] rd_addr, a;
  int seed = 32'h3d36_98d6;
  int mismatches = 0, checks_done = 0, n_next = 0, n_rst = 0, cyc = 0, n0;
  always #2 clk = ~clk;
  fwrc_ctrl #(.RCH_CYC(2), .DP_CYC(20), .RES1_CYC(20), .RES2_CYC(15), .RST_CYC(30),
    .DEVICE_ID(ID_VAL)) fwrc_ctrl_inst (.REF_CLK(clk), .NRST(nrst), .CE(ce),
    .CS_N(cs_n), .SCLK(sclk), .IO_IN(io_in), .QUAD_MODE(qm), .QUAD_ENABLE(qe),
    .BUSY(busy), .ARRAY_DATA(adat), .IO_OUT(io_out), .IO_OE_N(oe_n), .WRAP_SETTING(wrap),
    .READ_PARAM(rparam), .POWER_DOWN(pd), .SW_RESET(sw_rst), .CONT_READ(cont),
    .RD_ADDR(rd_addr), .RD_NEXT(rd_next), .READY(ready));
  fwrc_host fwrc_host_inst (.clk(clk), .io_out(io_out), .cs_n(cs_n), .sclk(sclk),
    .io_in(io_in));
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    adat <= 8'($random(seed));
    if (rd_next === 1'b1) n_next++;
    if (sw_rst === 1'b1) n_rst++;
    cyc++;
    if (cyc == 60000) begin
      mismatches++;
      conclude();
    end
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic settle();
    int k;
    k = 0;
    while (ready !== 1'b1 && k < 20000) begin
      tick(1);
      k++;
    end
    chk("ready", ready, 1'b1);
    tick(4);
  endtask
  task automatic op(input logic [7:0] x);
    fwrc_host_inst.start();
    fwrc_host_inst.send({24'h00_0000, x}, 8, 1);
    fwrc_host_inst.stop();
    tick(10);
  endtask
  task automatic setwrap(input logic [7:0] x);
    fwrc_host_inst.start();
    fwrc_host_inst.send({24'h00_0000, OP_SETWRAP}, 8, 1);
    fwrc_host_inst.send(32'h0000_0000, 24, 4);
    fwrc_host_inst.send({24'h00_0000, x}, 8, 4);
    fwrc_host_inst.stop();
    tick(10);
  endtask
  task automatic rd(input logic c, input logic [23:0] ad, input logic [7:0] m, input int nb);
    fwrc_host_inst.start();
    if (!c) fwrc_host_inst.send({24'h00_0000, OP_QIO}, 8, qm ? 4 : 1);
    fwrc_host_inst.send({8'h00, ad}, 24, 4);
    fwrc_host_inst.send({24'h00_0000, m}, 8, 4);
    // Closing fall of the frame drives the second nibble of the last byte
    fwrc_host_inst.clocks((qm ? 0 : 4) + 2 * nb - 1);
    fwrc_host_inst.stop();
    tick(10);
  endtask
  function automatic logic [23:0] exp_addr(logic [23:0] ad, int nb, logic [2:0] ws, logic q);
    logic [23:0] msk;
    msk = 24'((8 << ws[2:1]) - 1);
    if (ws[0] || q) return ad + 24'(nb);
    return (ad & ~msk) | ((ad + 24'(nb)) & msk);
  endfunction
  task automatic rdchk(input logic [23:0] ad, input int nb);
    n0 = n_next;
    rd(1'b0, ad, 8'h00, nb);
    chk("rd_count", n_next - n0, nb);
    chk("rd_addr", rd_addr, exp_addr(ad, nb, mws, qm));
  endtask
  initial begin
    tick(20);
    nrst <= 1'b1;
    tick(4);
    chk("wrap_rst", wrap, 3'b001);
    chk("pd_rst", pd, 1'b0);
    chk("param_rst", rparam, 8'h00);
    setwrap(8'h00);
    chk("wrap_noqe", wrap, 3'b001);
    n0 = n_next;
    rd(1'b0, 24'h00_0010, 8'h00, 2);
    chk("rd_noqe", n_next - n0, 0);
    $display("test quad_enable done");
    qe <= 1'b1;
    for (int l = 0; l < 5; l++) begin
      w = 8'($random(seed));
      w[6:4] = (l < 4) ? {l[1:0], 1'b0} : 3'b111;
      mws = w[6:4];
      setwrap(w);
      chk("wrap_set", wrap, mws);
      rdchk(24'($random(seed)), (8 << l[1:0]) + 3);
      rdchk(24'($random(seed)), 5);
    end
    $display("test wrap done");
    setwrap(8'h00);
    qm <= 1'b1;
    p = 8'($random(seed)) & 8'hCF;
    fwrc_host_inst.start();
    fwrc_host_inst.send({24'h00_0000, OP_RDPARAM}, 8, 4);
    fwrc_host_inst.send({24'h00_0000, p}, 8, 4);
    fwrc_host_inst.stop();
    tick(10);
    mws = {p[1:0], 1'b0};
    chk("param", rparam, p);
    chk("wrap_param", wrap, mws);
    rdchk(24'($random(seed)), 20);
    qm <= 1'b0;
    $display("test quad_mode done");
    op(OP_RSTEN);
    op(8'h05);
    n0 = n_rst;
    op(OP_RST);
    chk("rst_cancel", n_rst - n0, 0);
    op(OP_RSTEN);
    op(OP_RST);
    chk("rst_pulse", n_rst - n0, 1);
    chk("rst_ready", ready, 1'b0);
    chk("rst_wrap", wrap, 3'b001);
    chk("rst_param", rparam, 8'h00);
    ce <= 1'b0;
    tick(40);
    chk("ce_freeze", ready, 1'b0);
    ce <= 1'b1;
    settle();
    $display("test reset done");
    fwrc_host_inst.start();
    fwrc_host_inst.send({23'h00_0000, OP_SLEEP, 1'b0}, 9, 1);
    fwrc_host_inst.stop();
    tick(30);
    chk("pd_void", pd, 1'b0);
    op(OP_SLEEP);
    tick(30);
    chk("pd_on", pd, 1'b1);
    setwrap(8'h00);
    chk("pd_ignore", wrap, 3'b001);
    n0 = n_rst;
    op(OP_RSTEN);
    op(OP_RST);
    chk("pd_rst", n_rst - n0, 0);
    busy <= 1'b1;
    op(OP_WAKE);
    tick(30);
    chk("pd_busy", pd, 1'b1);
    busy <= 1'b0;
    op(OP_WAKE);
    tick(30);
    chk("pd_wake", pd, 1'b0);
    settle();
    op(OP_SLEEP);
    tick(30);
    fwrc_host_inst.start();
    fwrc_host_inst.send({OP_WAKE, 24'h00_0000}, 32, 1);
    fwrc_host_inst.clocks(16);
    fwrc_host_inst.stop();
    chk("dev_id", fwrc_host_inst.cap[15:0], {ID_VAL, ID_VAL});
    tick(25);
    chk("pd_wake_id", pd, 1'b0);
    chk("oe_idle", oe_n, 4'hF);
    settle();
    $display("test power_down done");
    rd(1'b0, 24'h00_0100, 8'h20, 2);
    chk("cont_on", cont, 1'b1);
    n0 = n_rst;
    rd(1'b1, {16'h0000, OP_RSTEN}, 8'h20, 1);
    rd(1'b1, {16'h0000, OP_RST}, 8'h20, 1);
    chk("cont_rst", n_rst - n0, 0);
    chk("cont_kept", cont, 1'b1);
    a = 24'($random(seed));
    n0 = n_next;
    rd(1'b1, a, 8'h00, 3);
    chk("cont_count", n_next - n0, 3);
    chk("cont_addr", rd_addr, a + 24'h00_0003);
    chk("cont_off", cont, 1'b0);
    $display("test continuous_read done");
    conclude();
  end
endmodule
